// File: bench/pcsa_host_model.sv
module pcsa_host_model
    import pcsa_pkg::*;
(
    // clock
    input wire logic clk,
    // card answer
    input wire logic [15:0] data_out,
    input wire logic [1:0] data_oe,
    input wire logic wide_port_n,
    // host drive
    output pcsa_bus_t host_bus,
    output logic [15:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        host_bus = {7'h7F, 11'h000};
        data_in = 16'h0000;
    end

    // ==========================================================
    // one host cycle, enables active low, io picks the strobe pair
    task automatic cyc(input logic rn, c1, c2, io, wr, input logic [10:0] a, input logic [15:0] d,
        output logic [15:0] q, output logic [1:0] oe, output logic wp);
        @(posedge clk);
        host_bus <= {rn, c1, c2, io | wr, io | !wr, !io | wr, !io | !wr, a};
        data_in <= d;
        @(posedge clk);
        if (wr)
        begin
            host_bus.write_enable_n <= 1'b1;
            host_bus.io_write_strobe_n <= 1'b1;
        end
        @(posedge clk);
        #1;
        q = data_out;
        oe = data_oe;
        wp = wide_port_n;
        @(posedge clk);
        // released lines must not look like the last value
        host_bus <= {7'h7F, ~a};
        data_in <= ~d;
    endtask
endmodule // pcsa_host_model

// File: bench/pcsa_port_tb.sv
`define CHK(g, e) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            error_cnt++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
`define WAIT(c, n) \
    begin \
        k = 0; \
        while (!(c) && k < (n)) \
        begin \
            @(posedge clk); \
            #1; \
            k++; \
        end \
    end

module pcsa_port_tb
    import pcsa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, sys_rst, status_change_n, wide_port_n, io_mode, int_request, irq_disable_n;
    logic core_ready, protect_live, command_strobe, io_write_pulse, power_saving, power_busy;
    logic keep, kick, wp;
    pcsa_bus_t host_bus;
    logic [15:0] data_in, data_out, io_read_word, io_write_word, q;
    logic [1:0] data_oe, io_byte_en, oe;
    logic [10:0] io_addr;
    logic [5:0] cnt;
    int error_cnt = 0;
    int n_checks = 0;
    int k;
    logic [7:0] pulses = 8'h00;
    logic [7:0] prr_w [5] = '{8'h00, 8'h01, 8'h33, 8'h12, 8'h03};
    logic [7:0] prr_e [5] = '{8'h1E, 8'h0E, 8'h3E, 8'h1E, 8'h0E};
    logic [1:0] io_ce [4] = '{2'b01, 2'b01, 2'b00, 2'b10};
    logic [10:0] io_a [4] = '{11'h1F1, 11'h1F0, 11'h1F0, 11'h1F1};
    logic [15:0] io_d [4] = '{16'h0055, 16'h0066, 16'hA1B2, 16'hC300};
    logic [17:0] io_we [4] = '{18'h25500, 18'h10066, 18'h3A1B2, 18'h2C300};
    logic [17:0] io_re [4] = '{18'h100BE, 18'h100EF, 18'h3BEEF, 18'h2BE00};

    pcsa_port #(.IDLE_CYCLES(200), .TRANS_CYCLES(3)) i_pcsa_port (
        .clk(clk), .sys_rst(sys_rst), .host_bus(host_bus), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .status_change_n(status_change_n),
        .wide_port_n(wide_port_n), .io_mode(io_mode), .int_request(int_request),
        .irq_disable_n(irq_disable_n), .core_ready(core_ready), .protect_live(protect_live),
        .command_strobe(command_strobe), .io_read_word(io_read_word), .io_addr(io_addr),
        .io_write_pulse(io_write_pulse), .io_byte_en(io_byte_en), .io_write_word(io_write_word),
        .power_saving(power_saving), .power_busy(power_busy));

    pcsa_host_model i_pcsa_host_model (
        .clk(clk), .data_out(data_out), .data_oe(data_oe), .wide_port_n(wide_port_n),
        .host_bus(host_bus), .data_in(data_in));

    always #20 clk = ~clk;

    // keeps the card awake except where a test wants it idle
    always @(posedge clk)
    begin
        cnt <= cnt + 6'h01;
        command_strobe <= (keep && cnt == 6'h00) || kick;
    end

    // write pulse lasts one cycle, so count it where it stands
    always @(posedge clk)
        if (io_write_pulse === 1'b1)
            pulses <= pulses + 8'h01;

    // ==========================================================
    // bus access tasks, m = {reg_n, low_n, high_n, io, write}
    task automatic hc(input logic [4:0] m, input logic [10:0] a, input logic [15:0] d);
        i_pcsa_host_model.cyc(m[4], m[3], m[2], m[1], m[0], a, d, q, oe, wp);
    endtask
    task automatic ar(input logic [10:0] a, input logic [7:0] e);
        hc(5'b00100, a, 16'h0000);
        `CHK({oe, q[7:0]}, {2'b01, e})
    endtask
    task automatic aw(input logic [10:0] a, input logic [7:0] d);
        hc(5'b00101, a, {8'h00, d});
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        stop_test();
    end

    // ==========================================================
    // test sequence
    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        io_mode = 1'b0;
        int_request = 1'b0;
        irq_disable_n = 1'b1;
        core_ready = 1'b0;
        protect_live = 1'b0;
        command_strobe = 1'b0;
        io_read_word = 16'hBEEF;
        keep = 1'b1;
        kick = 1'b0;
        cnt = 6'h00;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        ar(11'h202, 8'h00);
        ar(11'h204, 8'h0C);
        @(posedge clk) core_ready <= 1'b1;
        ar(11'h204, 8'h2E);
        ar(11'h202, 8'h80);
        aw(11'h204, 8'h02);
        aw(11'h202, 8'hE2);
        ar(11'h202, 8'h60);
        aw(11'h202, 8'h00);
        @(posedge clk) protect_live <= 1'b1;
        ar(11'h204, 8'h1E);
        for (int i = 0; i < 5; i++)
        begin
            aw(11'h204, prr_w[i]);
            ar(11'h204, prr_e[i]);
        end
        keep <= 1'b0;
        aw(11'h202, 8'h04);
        `WAIT(power_busy === 1'b1, 10)
        `CHK(power_busy, 1'b1)
        `WAIT(power_saving === 1'b1, 10)
        `CHK({power_saving, power_busy}, 2'b10)
        ar(11'h202, 8'h84);
        aw(11'h202, 8'h00);
        `WAIT(power_busy === 1'b0 && power_saving === 1'b0, 12)
        `CHK({power_saving, power_busy}, 2'b00)
        keep <= 1'b1;
        aw(11'h204, 8'h03);
        aw(11'h002, 8'h40);
        aw(11'h203, 8'h40);
        hc(5'b01001, 11'h202, 16'h4040);
        ar(11'h202, 8'h00);
        hc(5'b00000, 11'h204, 16'h0000);
        `CHK({oe, q[7:0]}, {2'b01, 8'h0E})
        @(posedge clk) io_mode <= 1'b1;
        aw(11'h202, 8'h40);
        repeat (2) @(posedge clk);
        #1;
        `CHK(status_change_n, 1'b0)
        aw(11'h202, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        `CHK(status_change_n, 1'b1)
        @(posedge clk) int_request <= 1'b1;
        ar(11'h202, 8'h82);
        ar(11'h204, 8'h2E);
        @(posedge clk) irq_disable_n <= 1'b0;
        ar(11'h202, 8'h80);
        ar(11'h204, 8'h2C);
        for (int i = 0; i < 4; i++)
        begin
            hc({1'b0, io_ce[i], 2'b11}, io_a[i], io_d[i]);
            #1;
            `CHK({pulses, io_byte_en, io_write_word, io_addr}, {8'(i + 1), io_we[i], io_a[i]})
            hc({1'b0, io_ce[i], 2'b10}, io_a[i], 16'h0000);
            `CHK({wp, oe, q & {{8{oe[1]}}, {8{oe[0]}}}}, {1'b0, io_re[i]})
        end
        hc(5'b10011, 11'h1F0, 16'h1234);
        #1;
        `CHK({pulses, io_write_word, io_addr}, {8'h04, 16'hC300, 11'h1F1})
        hc(5'b10010, 11'h1F0, 16'h0000);
        `CHK({oe, io_addr}, {2'b00, 11'h1F1})
        @(posedge clk) keep <= 1'b0;
        `WAIT(power_saving === 1'b1, 260)
        `CHK(power_saving, 1'b1)
        @(posedge clk) kick <= 1'b1;
        @(posedge clk) kick <= 1'b0;
        `WAIT(power_saving === 1'b0 && power_busy === 1'b0, 12)
        `CHK({power_saving, power_busy}, 2'b00)
        stop_test();
    end
endmodule // pcsa_port_tb

// File: src/pcsa_lane_steer.sv
module pcsa_lane_steer
    import pcsa_pkg::*;
(
    // lane selects
    input wire logic low_lane_enable_n,
    input wire logic high_lane_enable_n,
    input wire logic a0,
    // data
    input wire logic [15:0] core_word,
    input wire logic [15:0] pin_word,
    output logic [1:0] lane_en,
    output logic [15:0] to_pins,
    output logic [15:0] to_core,
    output logic [1:0] byte_en
);
    always_comb
    begin
        lane_en = 2'b00;
        to_pins = 16'h0000;
        to_core = 16'h0000;
        byte_en = 2'b00;
        if (!low_lane_enable_n && !high_lane_enable_n)
        begin
            lane_en = 2'b11;
            to_pins = core_word;
            to_core = pin_word;
            byte_en = 2'b11;
        end
        else if (!low_lane_enable_n)
        begin
            // single byte on the low enable always rides the low lane
            lane_en = 2'b01;
            to_pins = {8'h00, a0 ? core_word[15:8] : core_word[7:0]};
            to_core = a0 ? {pin_word[7:0], 8'h00} : {8'h00, pin_word[7:0]};
            byte_en = a0 ? 2'b10 : 2'b01;
        end
        else if (!high_lane_enable_n)
        begin
            lane_en = 2'b10;
            to_pins = {core_word[15:8], 8'h00};
            to_core = {pin_word[15:8], 8'h00};
            byte_en = 2'b10;
        end
    end
endmodule // pcsa_lane_steer

// File: src/pcsa_params.svh
`ifndef PCSA_PARAMS_SVH
`define PCSA_PARAMS_SVH
// ==========================================================
// clock and timing
`define PCSA_CLK_NS 40
`define PCSA_PWR_TRANS_NS 1000
`define PCSA_PWR_TRANS_CYC ((`PCSA_PWR_TRANS_NS + `PCSA_CLK_NS - 1) / `PCSA_CLK_NS)
`define PCSA_IDLE_US 5000
`define PCSA_IDLE_CYC (`PCSA_IDLE_US * 1000 / `PCSA_CLK_NS)
// ==========================================================
// attribute space map
`define PCSA_CFG_BASE 11'h200
`define PCSA_CCSR_ADDR 11'h202
`define PCSA_PRR_ADDR 11'h204
// ==========================================================
// status register fields
`define PCSA_CCSR_RST 8'h00
`define PCSA_CCSR_CHG 7
`define PCSA_CCSR_SIGEN 6
`define PCSA_CCSR_IO8 5
`define PCSA_CCSR_PWR 2
`define PCSA_CCSR_INT 1
// ==========================================================
// pin event register fields
`define PCSA_PRR_RST 8'h0C
`define PCSA_PRR_RCHG 5
`define PCSA_PRR_WCHG 4
`define PCSA_PRR_RDY 1
`define PCSA_PRR_WP 0
`endif

// File: src/pcsa_pkg.sv
package pcsa_pkg;
    // host strobes and address sampled each cycle
    typedef struct packed {
        logic reg_select_n;
        logic low_lane_enable_n;
        logic high_lane_enable_n;
        logic out_enable_n;
        logic write_enable_n;
        logic io_read_strobe_n;
        logic io_write_strobe_n;
        logic [10:0] addr;
    } pcsa_bus_t;

    // power state, gray coded around the loop
    typedef enum logic [1:0] {
        PCSA_ACTIVE = 2'b00,
        PCSA_TO_SAVE = 2'b01,
        PCSA_SAVE = 2'b11,
        PCSA_TO_ACTIVE = 2'b10
    } pcsa_pwr_t;
endpackage

// File: src/pcsa_port.sv
`include "pcsa_params.svh"
module pcsa_port
    import pcsa_pkg::*;
#(
    parameter int IDLE_CYCLES = `PCSA_IDLE_CYC,
    parameter int TRANS_CYCLES = `PCSA_PWR_TRANS_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host bus
    input wire pcsa_bus_t host_bus,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic [1:0] data_oe,
    output logic status_change_n,
    output logic wide_port_n,
    // card core side
    input wire logic io_mode,
    input wire logic int_request,
    input wire logic irq_disable_n,
    input wire logic core_ready,
    input wire logic protect_live,
    input wire logic command_strobe,
    input wire logic [15:0] io_read_word,
    output logic [10:0] io_addr,
    output logic io_write_pulse,
    output logic [1:0] io_byte_en,
    output logic [15:0] io_write_word,
    output logic power_saving,
    output logic power_busy
);
    // ==========================================================
    // decode helpers
    function automatic logic attr_hit(input logic [10:0] a, input logic [10:0] off);
        attr_hit = (a == off);
    endfunction
    function automatic logic attr_sel(input pcsa_bus_t b);
        // even address, low enable, register select
        attr_sel = !b.reg_select_n && !b.low_lane_enable_n && !b.addr[0];
    endfunction

    pcsa_bus_t prev_bus_ff;
    logic [15:0] prev_data_ff;
    logic change_signal_enable_ff;
    logic byte_io_request_ff;
    logic power_save_request_ff;
    logic ready_change_ff;
    logic protect_toggle_flag_ff;
    logic ready_seen_ff;
    logic protect_seen_ff;
    pcsa_pwr_t pwr_ff;
    logic pwr_req_seen_ff;
    logic [$clog2(TRANS_CYCLES+1)-1:0] trans_cnt_ff;
    logic [$clog2(IDLE_CYCLES+1)-1:0] idle_cnt_ff;
    logic int_bit;
    logic ready_bit;
    logic changed;
    logic attr_wr_done;
    logic ccsr_wr;
    logic prr_wr;
    logic io_wr_done;
    logic [7:0] ccsr_rd;
    logic [7:0] prr_rd;
    logic [1:0] lane_en;
    logic [15:0] lane_pins;
    logic [15:0] lane_core;
    logic [1:0] lane_be;
    logic [1:0] wlane_be;
    logic [15:0] wlane_core;

    // ==========================================================
    // status composition
    assign int_bit = int_request && irq_disable_n;
    assign ready_bit = io_mode ? int_bit : (core_ready && !power_busy);
    assign changed = ready_change_ff || protect_toggle_flag_ff;
    assign ccsr_rd = {changed, change_signal_enable_ff, byte_io_request_ff, 2'b00,
                      power_save_request_ff, int_bit, 1'b0};
    // protect switch absent: its bit is hard zero
    assign prr_rd = {2'b00, ready_change_ff, protect_toggle_flag_ff, 2'b11, ready_bit, 1'b0};

    // ==========================================================
    // write capture on the trailing edge of the strobe
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prev_bus_ff <= '1;
            prev_data_ff <= 16'h0000;
        end
        else
        begin
            prev_bus_ff <= host_bus;
            prev_data_ff <= data_in;
        end
    end

    // data still valid in the last asserted sample
    assign attr_wr_done = !prev_bus_ff.write_enable_n && host_bus.write_enable_n && attr_sel(prev_bus_ff);
    // info area (a10 = a9 = 0) never matches a register, so its writes vanish
    assign ccsr_wr = attr_wr_done && attr_hit(prev_bus_ff.addr, `PCSA_CCSR_ADDR);
    assign prr_wr = attr_wr_done && attr_hit(prev_bus_ff.addr, `PCSA_PRR_ADDR);
    assign io_wr_done = !prev_bus_ff.io_write_strobe_n && host_bus.io_write_strobe_n
                        && !prev_bus_ff.reg_select_n && io_mode;

    // ==========================================================
    // status register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            change_signal_enable_ff <= 1'(`PCSA_CCSR_RST >> `PCSA_CCSR_SIGEN);
            byte_io_request_ff <= 1'(`PCSA_CCSR_RST >> `PCSA_CCSR_IO8);
            power_save_request_ff <= 1'(`PCSA_CCSR_RST >> `PCSA_CCSR_PWR);
        end
        else if (ccsr_wr)
        begin
            // written bits 7 and 1 have no storage
            change_signal_enable_ff <= prev_data_ff[`PCSA_CCSR_SIGEN];
            byte_io_request_ff <= prev_data_ff[`PCSA_CCSR_IO8];
            power_save_request_ff <= prev_data_ff[`PCSA_CCSR_PWR];
        end
    end

    // ==========================================================
    // change flags: hardware set beats host write
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ready_change_ff <= 1'b0;
            protect_toggle_flag_ff <= 1'b0;
            ready_seen_ff <= 1'b0;
            protect_seen_ff <= 1'b0;
        end
        else
        begin
            ready_seen_ff <= ready_bit;
            protect_seen_ff <= protect_live;
            if (ready_bit != ready_seen_ff)
                ready_change_ff <= 1'b1;
            else if (prr_wr && prev_data_ff[`PCSA_PRR_RDY])
                ready_change_ff <= prev_data_ff[`PCSA_PRR_RCHG];
            if (protect_live != protect_seen_ff)
                protect_toggle_flag_ff <= 1'b1;
            else if (prr_wr && prev_data_ff[`PCSA_PRR_WP])
                protect_toggle_flag_ff <= prev_data_ff[`PCSA_PRR_WCHG];
        end
    end

    // ==========================================================
    // power state machine
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pwr_ff <= PCSA_ACTIVE;
            pwr_req_seen_ff <= 1'b0;
            trans_cnt_ff <= '0;
            idle_cnt_ff <= '0;
        end
        else
        begin
            pwr_req_seen_ff <= power_save_request_ff;
            if (command_strobe || pwr_ff != PCSA_ACTIVE)
                idle_cnt_ff <= '0;
            else if (idle_cnt_ff != IDLE_CYCLES[$bits(idle_cnt_ff)-1:0])
                idle_cnt_ff <= idle_cnt_ff + 1'b1;
            if (power_save_request_ff != pwr_req_seen_ff)
            begin
                // any change of the bit restarts a busy transition
                pwr_ff <= power_save_request_ff ? PCSA_TO_SAVE : PCSA_TO_ACTIVE;
                trans_cnt_ff <= TRANS_CYCLES[$bits(trans_cnt_ff)-1:0];
            end
            else
            begin
                case (pwr_ff)
                    PCSA_ACTIVE:
                        if (idle_cnt_ff == IDLE_CYCLES[$bits(idle_cnt_ff)-1:0] && !command_strobe)
                        begin
                            pwr_ff <= PCSA_TO_SAVE;
                            trans_cnt_ff <= TRANS_CYCLES[$bits(trans_cnt_ff)-1:0];
                        end
                    PCSA_SAVE:
                        if (command_strobe)
                        begin
                            pwr_ff <= PCSA_TO_ACTIVE;
                            trans_cnt_ff <= TRANS_CYCLES[$bits(trans_cnt_ff)-1:0];
                        end
                    PCSA_TO_SAVE, PCSA_TO_ACTIVE:
                        if (trans_cnt_ff <= 1)
                            pwr_ff <= (pwr_ff == PCSA_TO_SAVE) ? PCSA_SAVE : PCSA_ACTIVE;
                        else
                            trans_cnt_ff <= trans_cnt_ff - 1'b1;
                    default:
                        pwr_ff <= PCSA_ACTIVE;
                endcase
            end
        end
    end

    assign power_busy = (pwr_ff == PCSA_TO_SAVE) || (pwr_ff == PCSA_TO_ACTIVE);
    assign power_saving = (pwr_ff == PCSA_SAVE);

    // ==========================================================
    // io lane steering
    pcsa_lane_steer u_rd_steer (
        .low_lane_enable_n(host_bus.low_lane_enable_n),
        .high_lane_enable_n(host_bus.high_lane_enable_n),
        .a0(host_bus.addr[0]),
        .core_word(io_read_word),
        .pin_word(16'h0000),
        .lane_en(lane_en),
        .to_pins(lane_pins),
        .to_core(lane_core),
        .byte_en(lane_be)
    );
    pcsa_lane_steer u_wr_steer (
        .low_lane_enable_n(prev_bus_ff.low_lane_enable_n),
        .high_lane_enable_n(prev_bus_ff.high_lane_enable_n),
        .a0(prev_bus_ff.addr[0]),
        .core_word(16'h0000),
        .pin_word(prev_data_ff),
        .lane_en(),
        .to_pins(),
        .to_core(wlane_core),
        .byte_en(wlane_be)
    );

    // ==========================================================
    // registered pin and core outputs
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            data_out <= 16'h0000;
            data_oe <= 2'b00;
            status_change_n <= 1'b1;
            wide_port_n <= 1'b1;
            io_addr <= 11'h000;
            io_write_pulse <= 1'b0;
            io_byte_en <= 2'b00;
            io_write_word <= 16'h0000;
        end
        else
        begin
            data_out <= 16'h0000;
            data_oe <= 2'b00;
            if (attr_sel(host_bus) && !host_bus.out_enable_n && host_bus.write_enable_n)
            begin
                // odd lane left undriven on word reads
                data_oe <= 2'b01;
                if (attr_hit(host_bus.addr, `PCSA_CCSR_ADDR))
                    data_out <= {8'h00, ccsr_rd};
                else if (attr_hit(host_bus.addr, `PCSA_PRR_ADDR))
                    data_out <= {8'h00, prr_rd};
            end
            else if (io_mode && !host_bus.reg_select_n && !host_bus.io_read_strobe_n)
            begin
                data_oe <= lane_en;
                data_out <= lane_pins;
            end
            status_change_n <= !(io_mode && change_signal_enable_ff && changed);
            wide_port_n <= !(io_mode && !host_bus.reg_select_n
                             && !(host_bus.low_lane_enable_n && host_bus.high_lane_enable_n));
            if (io_mode && !host_bus.reg_select_n)
                io_addr <= host_bus.addr;
            io_write_pulse <= io_wr_done;
            if (io_wr_done)
            begin
                io_byte_en <= wlane_be;
                io_write_word <= wlane_core;
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_trans_last;
        power_busy && trans_cnt_ff == 1 && power_save_request_ff == pwr_req_seen_ff;
    endsequence
    sequence s_settled;
        !power_busy;
    endsequence
    a_change_line_low: assert property ((io_mode && change_signal_enable_ff && changed) |=> !status_change_n)
        else $error("status change line not low");
    a_change_line_high: assert property ((io_mode && !change_signal_enable_ff) |=> status_change_n)
        else $error("status change line not held high");
    a_pwr_busy: assert property ($changed(power_save_request_ff) |=> ##1 power_busy)
        else $error("no busy after power bit change");
    a_pwr_settle: assert property (s_trans_last |=> s_settled)
        else $error("power transition did not finish");
    a_ready_flag: assert property ((ready_bit != ready_seen_ff) |=> ready_change_ff)
        else $error("ready toggle not flagged");
    a_protect_flag: assert property ((protect_live != protect_seen_ff) |=> protect_toggle_flag_ff)
        else $error("protect toggle not flagged");
    a_mask_keep: assert property ((prr_wr && !prev_data_ff[`PCSA_PRR_RDY] && ready_bit == ready_seen_ff)
        |=> $stable(ready_change_ff))
        else $error("ready flag changed without mask");
    a_wide_port: assert property ((io_mode && !host_bus.reg_select_n && !host_bus.low_lane_enable_n)
        |=> !wide_port_n)
        else $error("wide port not asserted");
    a_inhibit_io: assert property ((host_bus.reg_select_n && !host_bus.io_read_strobe_n) |=> data_oe == 2'b00)
        else $error("data driven with select negated");
    a_attr_lane: assert property ((attr_sel(host_bus) && !host_bus.out_enable_n && host_bus.write_enable_n)
        |=> data_oe == 2'b01)
        else $error("attribute read lanes wrong");
    a_info_drop: assert property ((attr_wr_done && !prev_bus_ff.addr[10] && !prev_bus_ff.addr[9])
        |=> $stable(change_signal_enable_ff) && $stable(power_save_request_ff))
        else $error("info area write changed a register");
endmodule // pcsa_port
